// ---- gp789_pkg.sv ----
// Functional notes
// - First port pin-read returns live pin level for inputs, zero for outputs.
// - Second port has two pins, each with its own direction bit.
// - Second port pins feed timer inputs, or carry pulse/PWM outputs when selected.
// - Third port has two pins with own direction, shared with UART lines.
// - Third port outputs choose open-drain or push-pull per pin; open-drain never drives high.
// - Third port pull-up acts only in input mode or open-drain output.
// - Input-mode pin level goes to its peripheral input (first-port pin 4 has none) and the pin-read register.
`default_nettype none

package gp789_pkg;

    // Printed offsets are register indices; the byte address is four times the index
    localparam int unsigned IDX_W = 14;
    typedef logic [IDX_W-1:0] gp789_idx_t;

    localparam gp789_idx_t IDX_P7_LATCH = 14'h0007;
    localparam gp789_idx_t IDX_P8_LATCH = 14'h0008;
    localparam gp789_idx_t IDX_P9_LATCH = 14'h0009;
    localparam gp789_idx_t IDX_P7_READ = 14'h0014;
    localparam gp789_idx_t IDX_P8_READ = 14'h0015;
    localparam gp789_idx_t IDX_P9_READ = 14'h0016;
    localparam gp789_idx_t IDX_P7_DIR = 14'h0f21;
    localparam gp789_idx_t IDX_P8_DIR = 14'h0f22;
    localparam gp789_idx_t IDX_P9_DIR = 14'h0f23;
    localparam gp789_idx_t IDX_P9_PULLUP = 14'h0f30;
    localparam gp789_idx_t IDX_P7_FC = 14'h0f3b;
    localparam gp789_idx_t IDX_P8_FC = 14'h0f3c;
    localparam gp789_idx_t IDX_P9_FC = 14'h0f3d;
    localparam gp789_idx_t IDX_P9_DRIVE = 14'h0f4a;

    localparam int unsigned P7_W = 8;
    localparam int unsigned P8_W = 2;
    localparam int unsigned P9_W = 2;
    localparam int unsigned P7_FC_W = 5;

    // Bit positions of the first port's secondary functions
    localparam int unsigned P7_POS_PULSE = 0;
    localparam int unsigned P7_POS_TIMER_A = 2;
    localparam int unsigned P7_POS_DIVIDER = 4;
    localparam int unsigned P7_POS_EXT_INT = 5;

    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    typedef struct packed {
        logic [P7_W-1:0] port7_output_latch;
        logic [P8_W-1:0] port8_output_latch;
        logic [P9_W-1:0] port9_output_latch;
        logic [P7_W-1:0] port7_direction;
        logic [P8_W-1:0] port8_direction;
        logic [P9_W-1:0] port9_direction;
        logic [P7_FC_W-1:0] port7_function_select;
        logic [P8_W-1:0] port8_function_select;
        logic [P9_W-1:0] port9_function_select;
        logic [P9_W-1:0] port9_drive_type_select;
        logic [P9_W-1:0] port9_pullup_select;
    } gp789_regs_t;

    typedef struct packed {
        gp789_regs_t regs;
        logic [31:0] rdata;
        logic slverr;
        logic captured;
    } gp789_state_t;

    // Outputs of on-chip peripherals offered to the pins
    typedef struct packed {
        logic divider_output;
        logic [1:0] timer_a_pulse_output;
        logic [3:0] pulse_generator_output;
        logic [1:0] uart_tx;
    } gp789_periph_out_t;

    // Pin levels handed to on-chip peripherals
    typedef struct packed {
        logic [2:0] external_interrupt_line;
        logic [1:0] timer_a_input;
        logic [3:0] timer_counter_input;
        logic [1:0] uart_rx;
    } gp789_periph_in_t;

endpackage : gp789_pkg

`default_nettype wire

// ---- gp789_pin_cell.sv ----
`default_nettype none

module gp789_pin_cell #(
    parameter bit OD_CAPABLE = 1'b0
) (
    input wire logic dir_in,
    input wire logic func_in,
    input wire logic latch_in,
    input wire logic periph_in,
    input wire logic open_drain_in,
    input wire logic pullup_sel_in,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_out,
    output logic pull_en_out,
    output logic read_out,
    output logic to_periph_out
);

    logic drive;
    logic od;

    assign drive = func_in ? periph_in : latch_in;
    assign od = OD_CAPABLE & open_drain_in;
    assign pad_out = drive;
    // Open-drain only ever sinks: the high side stays off
    assign pad_oe_out = dir_in & (~od | ~drive);
    assign pull_en_out = OD_CAPABLE & pullup_sel_in & (~dir_in | od);
    // An open-drain output still reads the wire, which may be pulled low outside
    assign read_out = (~dir_in | od) & pad_in;
    assign to_periph_out = ~dir_in & pad_in;

endmodule : gp789_pin_cell

`default_nettype wire

// ---- gp789_ports.sv ----
// The APB interface to the registers was chosen for this implementation.
`default_nettype none

module gp789_ports
    import gp789_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
) (
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    input wire logic CE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [P7_W-1:0] P7_PIN_IN,
    output logic [P7_W-1:0] P7_PIN_OUT,
    output logic [P7_W-1:0] P7_PIN_OE_OUT,
    input wire logic [P8_W-1:0] P8_PIN_IN,
    output logic [P8_W-1:0] P8_PIN_OUT,
    output logic [P8_W-1:0] P8_PIN_OE_OUT,
    input wire logic [P9_W-1:0] P9_PIN_IN,
    output logic [P9_W-1:0] P9_PIN_OUT,
    output logic [P9_W-1:0] P9_PIN_OE_OUT,
    output logic [P9_W-1:0] P9_PULLUP_EN_OUT,
    input wire gp789_periph_out_t PERIPH_OUT_IN,
    output gp789_periph_in_t PERIPH_IN_OUT
);

    if (ADDR_W < IDX_W + 2) begin : g_addr_check
        $error("ADDR_W too narrow for the register map");
    end

    gp789_state_t st;
    gp789_state_t next_st;

    logic xfer_done;
    logic hit;
    logic [7:0] read_mux;
    gp789_idx_t reg_idx;
    logic addr_hi_zero;

    logic [P7_W-1:0] p7_read;
    logic [P7_W-1:0] p7_to_periph;
    logic [P7_W-1:0] p7_periph;
    logic [P7_W-1:0] p7_func;
    logic [P8_W-1:0] p8_read;
    logic [P8_W-1:0] p8_to_periph;
    logic [P9_W-1:0] p9_read;
    logic [P9_W-1:0] p9_to_periph;
    logic [P7_W-1:0] unused_pull7;
    logic [P8_W-1:0] unused_pull8;

    // Secondary outputs per pin; the top three pins have none
    assign p7_periph = {3'h0, PERIPH_OUT_IN.divider_output,
        PERIPH_OUT_IN.timer_a_pulse_output, PERIPH_OUT_IN.pulse_generator_output[1:0]};
    assign p7_func = {3'h0, st.regs.port7_function_select};

    // Pins without a secondary output simply follow the latch
    for (genvar i = 0; i < P7_W; i++) begin : g_p7
        gp789_pin_cell #(.OD_CAPABLE(1'b0)) u_cell (
            .dir_in(st.regs.port7_direction[i]),
            .func_in(p7_func[i]),
            .latch_in(st.regs.port7_output_latch[i]),
            .periph_in(p7_periph[i]),
            .open_drain_in(1'b0),
            .pullup_sel_in(1'b0),
            .pad_in(P7_PIN_IN[i]),
            .pad_out(P7_PIN_OUT[i]),
            .pad_oe_out(P7_PIN_OE_OUT[i]),
            .pull_en_out(unused_pull7[i]),
            .read_out(p7_read[i]),
            .to_periph_out(p7_to_periph[i])
        );
    end

    for (genvar i = 0; i < P8_W; i++) begin : g_p8
        gp789_pin_cell #(.OD_CAPABLE(1'b0)) u_cell (
            .dir_in(st.regs.port8_direction[i]),
            .func_in(st.regs.port8_function_select[i]),
            .latch_in(st.regs.port8_output_latch[i]),
            .periph_in(PERIPH_OUT_IN.pulse_generator_output[2+i]),
            .open_drain_in(1'b0),
            .pullup_sel_in(1'b0),
            .pad_in(P8_PIN_IN[i]),
            .pad_out(P8_PIN_OUT[i]),
            .pad_oe_out(P8_PIN_OE_OUT[i]),
            .pull_en_out(unused_pull8[i]),
            .read_out(p8_read[i]),
            .to_periph_out(p8_to_periph[i])
        );
    end

    for (genvar i = 0; i < P9_W; i++) begin : g_p9
        gp789_pin_cell #(.OD_CAPABLE(1'b1)) u_cell (
            .dir_in(st.regs.port9_direction[i]),
            .func_in(st.regs.port9_function_select[i]),
            .latch_in(st.regs.port9_output_latch[i]),
            .periph_in(PERIPH_OUT_IN.uart_tx[i]),
            .open_drain_in(st.regs.port9_drive_type_select[i]),
            .pullup_sel_in(st.regs.port9_pullup_select[i]),
            .pad_in(P9_PIN_IN[i]),
            .pad_out(P9_PIN_OUT[i]),
            .pad_oe_out(P9_PIN_OE_OUT[i]),
            .pull_en_out(P9_PULLUP_EN_OUT[i]),
            .read_out(p9_read[i]),
            .to_periph_out(p9_to_periph[i])
        );
    end

    always_comb begin
        PERIPH_IN_OUT.external_interrupt_line = p7_to_periph[P7_W-1:P7_POS_EXT_INT];
        PERIPH_IN_OUT.timer_a_input = p7_to_periph[P7_POS_TIMER_A+1:P7_POS_TIMER_A];
        PERIPH_IN_OUT.timer_counter_input = {p8_to_periph,
            p7_to_periph[P7_POS_PULSE+1:P7_POS_PULSE]};
        PERIPH_IN_OUT.uart_rx = p9_to_periph;
    end

    // Address decode: word index plus a check that no bit above the map is set
    assign reg_idx = PADDR_IN[IDX_W+1:2];
    assign addr_hi_zero = (PADDR_IN >> (IDX_W + 2)) == '0;

    always_comb begin
        hit = addr_hi_zero;
        read_mux = 8'h00;
        case (reg_idx)
            IDX_P7_LATCH: read_mux = st.regs.port7_output_latch;
            IDX_P8_LATCH: read_mux = {6'h00, st.regs.port8_output_latch};
            IDX_P9_LATCH: read_mux = {6'h00, st.regs.port9_output_latch};
            IDX_P7_READ: read_mux = p7_read;
            IDX_P8_READ: read_mux = {6'h00, p8_read};
            IDX_P9_READ: read_mux = {6'h00, p9_read};
            IDX_P7_DIR: read_mux = st.regs.port7_direction;
            IDX_P8_DIR: read_mux = {6'h00, st.regs.port8_direction};
            IDX_P9_DIR: read_mux = {6'h00, st.regs.port9_direction};
            IDX_P9_PULLUP: read_mux = {6'h00, st.regs.port9_pullup_select};
            IDX_P7_FC: read_mux = {3'h0, st.regs.port7_function_select};
            IDX_P8_FC: read_mux = {6'h00, st.regs.port8_function_select};
            IDX_P9_FC: read_mux = {6'h00, st.regs.port9_function_select};
            IDX_P9_DRIVE: read_mux = {6'h00, st.regs.port9_drive_type_select};
            default: hit = 1'b0;
        endcase
    end

    // The access phase waits for a sample taken with the clock enabled, so a
    // read never returns data from a frozen cycle
    assign xfer_done = PSEL_IN & PENABLE_IN & st.captured & CE_IN;
    assign PREADY_OUT = xfer_done;
    assign PSLVERR_OUT = xfer_done & st.slverr;
    assign PRDATA_OUT = st.rdata;

    always_comb begin
        next_st = st;
        if (CE_IN) begin
            if (PSEL_IN && !xfer_done) begin
                next_st.captured = 1'b1;
                next_st.rdata = {24'h000000, read_mux};
                next_st.slverr = !hit;
            end
            if (xfer_done) begin
                next_st.captured = 1'b0;
                // Only byte lane 0 carries register bits
                if (PWRITE_IN && PSTRB_IN[0] && !st.slverr) begin
                    case (reg_idx)
                        IDX_P7_LATCH: next_st.regs.port7_output_latch = PWDATA_IN[P7_W-1:0];
                        IDX_P8_LATCH: next_st.regs.port8_output_latch = PWDATA_IN[P8_W-1:0];
                        IDX_P9_LATCH: next_st.regs.port9_output_latch = PWDATA_IN[P9_W-1:0];
                        IDX_P7_DIR: next_st.regs.port7_direction = PWDATA_IN[P7_W-1:0];
                        IDX_P8_DIR: next_st.regs.port8_direction = PWDATA_IN[P8_W-1:0];
                        IDX_P9_DIR: next_st.regs.port9_direction = PWDATA_IN[P9_W-1:0];
                        IDX_P9_PULLUP: next_st.regs.port9_pullup_select = PWDATA_IN[P9_W-1:0];
                        IDX_P7_FC: next_st.regs.port7_function_select = PWDATA_IN[P7_FC_W-1:0];
                        IDX_P8_FC: next_st.regs.port8_function_select = PWDATA_IN[P8_W-1:0];
                        IDX_P9_FC: next_st.regs.port9_function_select = PWDATA_IN[P9_W-1:0];
                        IDX_P9_DRIVE: next_st.regs.port9_drive_type_select = PWDATA_IN[P9_W-1:0];
                        default: next_st.regs = st.regs;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            // Every pin comes up as an input with its latch low
            st.regs.port7_output_latch <= RST_LATCH[P7_W-1:0];
            st.regs.port8_output_latch <= RST_LATCH[P8_W-1:0];
            st.regs.port9_output_latch <= RST_LATCH[P9_W-1:0];
            st.regs.port7_direction <= RST_CTRL[P7_W-1:0];
            st.regs.port8_direction <= RST_CTRL[P8_W-1:0];
            st.regs.port9_direction <= RST_CTRL[P9_W-1:0];
            st.regs.port7_function_select <= RST_CTRL[P7_FC_W-1:0];
            st.regs.port8_function_select <= RST_CTRL[P8_W-1:0];
            st.regs.port9_function_select <= RST_CTRL[P9_W-1:0];
            st.regs.port9_drive_type_select <= RST_CTRL[P9_W-1:0];
            st.regs.port9_pullup_select <= RST_CTRL[P9_W-1:0];
            st.rdata <= 32'h00000000;
            st.slverr <= 1'b0;
            st.captured <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    AST_P7_READ_GATED: assert property (
        (PREADY_OUT && !PWRITE_IN && reg_idx == IDX_P7_READ && addr_hi_zero
            && $past(CE_IN) && !$past(st.captured))
        |-> ##1 PRDATA_OUT == {24'h000000,
            $past(P7_PIN_IN, 2) & ~$past(st.regs.port7_direction, 2)})
        else $error("port 7 pin read not gated by direction");

    AST_P8_DIR_WRITE: assert property (
        (PREADY_OUT && PWRITE_IN && PSTRB_IN[0] && reg_idx == IDX_P8_DIR && addr_hi_zero)
        |=> P8_PIN_OE_OUT == $past(PWDATA_IN[P8_W-1:0]))
        else $error("port 8 direction write not reflected on enables");

    AST_P8_TIMER_OUT: assert property (
        ((P8_PIN_OUT ^ PERIPH_OUT_IN.pulse_generator_output[3:2])
            & st.regs.port8_direction & st.regs.port8_function_select) == '0)
        else $error("port 8 pin does not carry pulse output");

    AST_P9_UART: assert property (
        (PERIPH_IN_OUT.uart_rx == (P9_PIN_IN & ~st.regs.port9_direction))
        && (((P9_PIN_OUT ^ PERIPH_OUT_IN.uart_tx) & st.regs.port9_direction
            & st.regs.port9_function_select) == '0))
        else $error("port 9 UART routing wrong");

    AST_P9_OPEN_DRAIN: assert property (
        ((P9_PIN_OE_OUT & P9_PIN_OUT & st.regs.port9_drive_type_select) == '0)
        && ((P9_PIN_OE_OUT ^ st.regs.port9_direction) & ~st.regs.port9_drive_type_select) == '0)
        else $error("port 9 open-drain pin drives high or push-pull pin floats");

    AST_P9_PULLUP: assert property (
        P9_PULLUP_EN_OUT == (st.regs.port9_pullup_select
            & (~st.regs.port9_direction | st.regs.port9_drive_type_select)))
        else $error("port 9 pull-up enabled outside its modes");

    AST_P7_PERIPH_IN: assert property (
        {PERIPH_IN_OUT.external_interrupt_line, PERIPH_IN_OUT.timer_a_input}
            == ({P7_PIN_IN[7:5], P7_PIN_IN[3:2]}
            & ~{st.regs.port7_direction[7:5], st.regs.port7_direction[3:2]}))
        else $error("port 7 input not routed to peripheral");

    AST_P7_LATCH_DRIVE: assert property (
        (st.regs.port7_direction[7:5] == 3'h7)
        |-> P7_PIN_OUT[7:5] == st.regs.port7_output_latch[7:5] && P7_PIN_OE_OUT[7:5] == 3'h7)
        else $error("port 7 latch-only pins not driven from latch");

    AST_UNMAPPED_ERR: assert property (
        (PSEL_IN && !PENABLE_IN && CE_IN && !st.captured && !hit)
        ##1 (PSEL_IN && PENABLE_IN && CE_IN) |-> PSLVERR_OUT)
        else $error("unmapped access not flagged");

    CV_P9_OPEN_DRAIN_LOW: cover property (
        P9_PIN_OE_OUT[0] && st.regs.port9_drive_type_select[0]);
    CV_P7_READ: cover property (
        PREADY_OUT && !PWRITE_IN && reg_idx == IDX_P7_READ);
    CV_P8_PULSE: cover property (
        st.regs.port8_direction[1] && st.regs.port8_function_select[1]);

endmodule : gp789_ports

`default_nettype wire

// ---- gp789_pin_model.sv ----
`default_nettype none

module gp789_pin_model
    import gp789_pkg::*;
(
    input wire logic [11:0] dev_out_in,
    input wire logic [11:0] dev_oe_in,
    input wire logic [P9_W-1:0] pullup_en_in,
    input wire logic [11:0] ext_level_in,
    output logic [11:0] pad_level_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Serial routing of the shared third-port lines is configured outside this block
    localparam bit SERIAL_ROUTE_SET = 1'b1;

    logic [11:0] pulled;

    // External sources are weak keepers: device drive wins, then the pull-up
    always_comb begin
        pulled = {pullup_en_in, 10'h000};
        for (int i = 0; i < 12; i++) begin
            pad_level_out[i] = dev_oe_in[i] ? dev_out_in[i] : (pulled[i] | ext_level_in[i]);
        end
        if (!SERIAL_ROUTE_SET) begin
            pad_level_out[11:10] = 2'b11;
        end
    end
endmodule : gp789_pin_model

`default_nettype wire

// ---- gp789_ports_bench.sv ----
`default_nettype none

module gp789_ports_bench
    import gp789_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [11:0] ext, e_oe, e_out, e_rd, e_in;
    logic [1:0] pu, e_pu;
    wire [11:0] pad, dout, doe;
    gp789_periph_out_t per_o;
    gp789_periph_in_t per_i;
    int seed = 14441;
    int num_errors = 0;
    int samples_checked = 0;
    int mreg [11];
    localparam gp789_idx_t IDX_TAB [15] = '{IDX_P7_LATCH, IDX_P8_LATCH, IDX_P9_LATCH,
        IDX_P7_DIR, IDX_P8_DIR, IDX_P9_DIR, IDX_P9_PULLUP, IDX_P7_FC, IDX_P8_FC, IDX_P9_FC,
        IDX_P9_DRIVE, IDX_P7_READ, IDX_P8_READ, IDX_P9_READ, 14'h0010};
    localparam int MASK_TAB [11] = '{8'hff, 8'h03, 8'h03, 8'hff, 8'h03, 8'h03, 8'h03,
        8'h1f, 8'h03, 8'h03, 8'h03};

    gp789_ports uut (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce), .PADDR_IN(paddr),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PWDATA_IN(pwdata),
        .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .P7_PIN_IN(pad[7:0]), .P7_PIN_OUT(dout[7:0]), .P7_PIN_OE_OUT(doe[7:0]),
        .P8_PIN_IN(pad[9:8]), .P8_PIN_OUT(dout[9:8]), .P8_PIN_OE_OUT(doe[9:8]),
        .P9_PIN_IN(pad[11:10]), .P9_PIN_OUT(dout[11:10]), .P9_PIN_OE_OUT(doe[11:10]),
        .P9_PULLUP_EN_OUT(pu), .PERIPH_OUT_IN(per_o), .PERIPH_IN_OUT(per_i));

    gp789_pin_model pins (.dev_out_in(dout), .dev_oe_in(doe), .pullup_en_in(pu),
        .ext_level_in(ext), .pad_level_out(pad));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Random clock-enable gaps stretch transfers without changing their meaning
    always @(posedge clk) begin
        ce <= ($random(seed) & 7) != 0;
    end

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: bus result %h, expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_pin(input logic [11:0] got, input logic [11:0] exp, input logic [11:0] m);
        samples_checked++;
        if ((got & m) !== (exp & m)) begin
            num_errors++;
            $display("Error at %0t: pin vector %h, expected %h", $time, got & m, exp & m);
        end
    endtask : cmp_pin

    task automatic model_pins();
        int p, i, d, od, v, up, pin;
        logic [11:0] pv;
        pv = {per_o.uart_tx, per_o.pulse_generator_output[3:2], 3'b000, per_o.divider_output,
            per_o.timer_a_pulse_output, per_o.pulse_generator_output[1:0]};
        for (int b = 0; b < 12; b++) begin
            p = (b < 8) ? 0 : ((b < 10) ? 1 : 2);
            i = b - ((p == 0) ? 0 : ((p == 1) ? 8 : 10));
            d = (mreg[3 + p] >> i) & 1;
            od = (p == 2) ? ((mreg[10] >> i) & 1) : 0;
            v = ((mreg[7 + p] >> i) & 1) ? int'(pv[b]) : ((mreg[p] >> i) & 1);
            e_out[b] = v[0];
            e_oe[b] = d[0] & ~(od[0] & v[0]);
            up = (p == 2) ? (((mreg[6] >> i) & 1) & (!d || od)) : 0;
            if (p == 2) begin
                e_pu[i] = up[0];
            end
            pin = e_oe[b] ? v : (up ? 1 : int'(ext[b]));
            e_rd[b] = pin[0] & (!d || od);
            e_in[b] = pin[0] & !d;
        end
    endtask : model_pins

    task automatic apb(input logic wr, input gp789_idx_t idx, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        // A stalled slave is left to the watchdog, which closes the run
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
    endtask : apb

    task automatic xfer(input logic wr, input int k, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] rd, exp;
        logic er;
        model_pins();
        exp = (k == 11) ? {24'h0, e_rd[7:0]} : (k == 12) ? {30'h0, e_rd[9:8]} :
            (k == 13) ? {30'h0, e_rd[11:10]} : (k < 11) ? mreg[k] : 32'h0;
        apb(wr, IDX_TAB[k], wd, st, rd, er);
        cmp_reg({31'h0, er}, {31'h0, k == 14});
        if (!wr) begin
            cmp_reg(rd, exp);
        end
        if (wr && k < 11 && st[0]) begin
            mreg[k] = wd & MASK_TAB[k];
        end
    endtask : xfer

    task automatic idle_check();
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        model_pins();
        cmp_pin(doe, e_oe, 12'hfff);
        cmp_pin(dout, e_out, e_oe);
        cmp_pin({pu, 10'h000}, {e_pu, 10'h000}, 12'hc00);
        cmp_pin({1'b0, per_i}, {1'b0, e_in[7:5], e_in[3:2], e_in[9:8], e_in[1:0], e_in[11:10]},
            12'h7ff);
        @(posedge clk);
    endtask : idle_check

    initial begin
        logic [31:0] r, w;
        rst_n = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        ext = 12'h000;
        per_o = '0;
        foreach (mreg[j]) mreg[j] = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int pass = 0; pass < 2; pass++) begin
            @(posedge clk);
            for (int k = 0; k < 15; k++) xfer(1'b0, k, 32'h0, 4'hf);
            idle_check();
            for (int n = 0; n < 250; n++) begin
                r = $random(seed);
                w = $random(seed);
                if (r[31:30] == 2'b00) begin
                    ext <= w[27:16];
                    per_o <= r[28:20];
                end
                idle_check();
                xfer(r[4], $unsigned(r[15:8]) % 15, w, r[3:0]);
                if (r[5]) xfer(1'b0, $unsigned(r[15:8]) % 15, 32'h0, 4'hf);
            end
            // Second reset in mid-run must bring every register back to input mode;
            // the bus is idled first so no stale access is captured after release
            psel <= 1'b0;
            penable <= 1'b0;
            rst_n <= 1'b0;
            repeat (2) @(posedge clk);
            foreach (mreg[j]) mreg[j] = 0;
            rst_n <= 1'b1;
        end
        end_of_test();
    end

    initial begin
        #500000;
        num_errors++;
        end_of_test();
    end
endmodule : gp789_ports_bench

`default_nettype wire
